// *** core/rtcc_cal_cycle.sv ***
/*
  Second and minute position within the 64-minute calibration cycle.
  Assumes secondPulse marks the end of each corrected second.
*/

`default_nettype none

module rtcc_cal_cycle
  import rtcc_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // timing
  input  wire logic       secondPulse,
  // position
  output var  logic [5:0] secondPos,
  output var  logic [5:0] minutePos,
  output var  logic       newSecond
);

  // ****************************************************************
  // counters
  // ****************************************************************
  logic       minuteRoll;
  logic [5:0] secondPos_next;
  logic [5:0] minutePos_next;

  assign minuteRoll     = secondPulse && (secondPos == SECOND_LAST);
  assign secondPos_next = minuteRoll ? SECOND_ZERO
                        : (secondPulse ? secondPos + SECOND_STEP : secondPos);
  // six bits wrap by themselves after minute 63
  assign minutePos_next = minuteRoll ? minutePos + MINUTE_STEP : minutePos;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      secondPos <= SECOND_ZERO;
      minutePos <= MINUTE_ZERO;
      newSecond <= 1'b0;
    end else begin
      secondPos <= secondPos_next;
      minutePos <= minutePos_next;
      newSecond <= secondPulse;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_MINUTE_ADVANCE: assert property (@(posedge clock) disable iff (reset)
    minuteRoll |=> (minutePos == $past(minutePos) + MINUTE_STEP) && (secondPos == SECOND_ZERO))
    else $error("minute position did not advance on rollover");

endmodule

`default_nettype wire

// *** core/rtcc_calibration.sv ***
/*
  Calibration and test-output block: control register at location 7,
  the corrected divide-by-256 stage that makes the second, and the
  open-drain test/level pin.
  Assumes register requests arrive already decoded from the serial
  interface, and oscTick is one pulse per crystal cycle.
*/

`default_nettype none

module rtcc_calibration
  import rtcc_pkg::*;
(
  // clock and reset
  input  wire logic            clock,
  input  wire logic            reset,
  // oscillator
  input  wire logic            oscTick,
  // register port
  input  wire rtcc_regreq_type regRequest,
  output var  logic [7:0]      regReadData,
  output var  logic            regReadValid,
  // timekeeping
  output var  logic            secondTick,
  // test/level pin, open drain
  input  wire logic            testPinIn,
  output var  logic            testPinOut,
  output var  logic            testPinEnableN
);

  // ****************************************************************
  // decoding
  // ****************************************************************
  function automatic logic isCtrlAddr(input logic [5:0] addr);
    isCtrlAddr = (addr == CTRL_ADDR);
  endfunction

  // ****************************************************************
  // control register
  // ****************************************************************
  rtcc_ctrl_type ctrl_reg;
  rtcc_ctrl_type ctrl_next;
  logic          ctrlWrite;
  logic          ctrlRead;
  logic [7:0]    readData_next;

  assign ctrlWrite     = regRequest.write && isCtrlAddr(regRequest.addr);
  assign ctrlRead      = regRequest.read && isCtrlAddr(regRequest.addr);
  assign ctrl_next     = ctrlWrite ? rtcc_ctrl_type'(regRequest.data) : ctrl_reg;
  assign readData_next = ctrlRead ? ctrl_reg : READ_ZERO;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg <= rtcc_ctrl_type'(CTRL_RESET);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      regReadData  <= READ_ZERO;
      regReadValid <= 1'b0;
    end else begin
      regReadData  <= readData_next;
      regReadValid <= regRequest.read;
    end
  end

  // ****************************************************************
  // prescaler and cycle position
  // ****************************************************************
  logic       stageTick;
  logic       testSquare;
  logic       secondPulse;
  logic [5:0] secondPos;
  logic [5:0] minutePos;
  logic       newSecond;

  rtcc_divider i_rtcc_divider (
    .clock      (clock),
    .reset      (reset),
    .oscTick    (oscTick),
    .stageTick  (stageTick),
    .testSquare (testSquare)
  );

  rtcc_cal_cycle i_rtcc_cal_cycle (
    .clock       (clock),
    .reset       (reset),
    .secondPulse (secondPulse),
    .secondPos   (secondPos),
    .minutePos   (minutePos),
    .newSecond   (newSecond)
  );

  // ****************************************************************
  // correction window
  // ****************************************************************
  logic [5:0] affectedMinutes;
  logic       minuteAffected;
  logic       secondSelected;
  logic       windowOpen;

  // 2N minutes; with N at most 31 this never passes minute 62
  assign affectedMinutes = {ctrl_reg.magnitude, 1'b0};
  assign minuteAffected  = (minutePos < affectedMinutes) && (minutePos < MINUTE_LIMIT);
  assign secondSelected  = (secondPos == CORR_SECOND);
  assign windowOpen      = newSecond && secondSelected && minuteAffected;

  // ****************************************************************
  // correction sequencer
  // ****************************************************************
  rtcc_corr_type corrState_reg;
  rtcc_corr_type corrState_next;
  logic [7:0]    stage_reg;
  logic          applyPoint;
  logic          applyNeg;
  logic          applyPos;
  logic          applyAny;

  assign applyPoint = stageTick && (corrState_reg == CORR_PENDING)
                    && (stage_reg == STAGE_CORR_POINT);
  // the sign is read at the moment of correction, not when armed
  assign applyNeg   = applyPoint && !ctrl_reg.signPositive;
  assign applyPos   = applyPoint && ctrl_reg.signPositive;
  assign applyAny   = applyNeg || applyPos;

  always_comb begin
    corrState_next = corrState_reg;
    case (corrState_reg)
      CORR_IDLE: begin
        if (windowOpen) begin
          corrState_next = CORR_PENDING;
        end
      end
      CORR_PENDING: begin
        // one correction only, then wait for the next selected second
        if (applyAny) begin
          corrState_next = CORR_IDLE;
        end
      end
      default: begin
        corrState_next = CORR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      corrState_reg <= CORR_IDLE;
    end else begin
      corrState_reg <= corrState_next;
    end
  end

  // ****************************************************************
  // corrected divide-by-256 stage
  // ****************************************************************
  logic [7:0] stage_next;
  logic       stageWrap;

  // the correction point is mid-count, so a split step never crosses the wrap
  assign stageWrap = stageTick && !applyAny && (stage_reg == STAGE_LAST);

  always_comb begin
    stage_next = stage_reg;
    if (stageTick) begin
      if (applyNeg) begin
        stage_next = stage_reg;
      end else if (applyPos) begin
        stage_next = stage_reg + STAGE_SPLIT_STEP;
      end else if (stageWrap) begin
        stage_next = STAGE_ZERO;
      end else begin
        stage_next = stage_reg + STAGE_STEP;
      end
    end
  end

  assign secondPulse = stageWrap;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage_reg  <= STAGE_ZERO;
      secondTick <= 1'b0;
    end else begin
      stage_reg  <= stage_next;
      secondTick <= secondPulse;
    end
  end

  // ****************************************************************
  // test / level pin
  // ****************************************************************
  logic pinLow_next;

  // low enable pulls the line down; a high level is left to the pull-up
  assign pinLow_next = ctrl_reg.frequency_test_enable ? !testSquare
                     : !ctrl_reg.levelOut;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      testPinOut     <= 1'b0;
      testPinEnableN <= 1'b1;
    end else begin
      testPinOut     <= 1'b0;
      testPinEnableN <= !pinLow_next;
    end
  end

  // the pin level is not used inside; it is kept for a later readback path
  logic pinSeen;
  assign pinSeen = testPinIn;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_TEST_FOLLOWS_TAP: assert property (@(posedge clock) disable iff (reset)
    ctrl_reg.frequency_test_enable |=> (testPinEnableN == $past(testSquare)))
    else $error("test pin does not follow the 512 Hz tap");

  AST_LEVEL_OUT: assert property (@(posedge clock) disable iff (reset)
    !ctrl_reg.frequency_test_enable |=> (testPinEnableN == $past(ctrl_reg.levelOut)))
    else $error("test pin does not show the level bit");

  AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (reset)
    testPinOut == 1'b0)
    else $error("test pin driven high");

  AST_BLANK: assert property (@(posedge clock) disable iff (reset)
    applyNeg |=> (stage_reg == $past(stage_reg)) && !secondTick)
    else $error("negative correction did not blank a stage pulse");

  AST_SPLIT: assert property (@(posedge clock) disable iff (reset)
    applyPos |=> (stage_reg == $past(stage_reg) + STAGE_SPLIT_STEP))
    else $error("positive correction did not add two stage counts");

  AST_SIGN: assert property (@(posedge clock) disable iff (reset)
    applyAny |-> (applyPos == ctrl_reg.signPositive) && (applyNeg == !ctrl_reg.signPositive))
    else $error("correction direction differs from the sign bit");

  AST_WINDOW: assert property (@(posedge clock) disable iff (reset)
    $rose(corrState_reg == CORR_PENDING)
      |-> ($past(minutePos) < {$past(ctrl_reg.magnitude), 1'b0})
          && ($past(minutePos) < MINUTE_LIMIT))
    else $error("correction armed outside the first 2N minutes");

  AST_FIXED_SECOND: assert property (@(posedge clock) disable iff (reset)
    applyAny |-> (secondPos == CORR_SECOND))
    else $error("correction outside the selected second");

  AST_ONE_PER_SECOND: assert property (@(posedge clock) disable iff (reset)
    applyAny |=> (corrState_reg == CORR_IDLE))
    else $error("more than one correction in a second");

  AST_NO_MAGNITUDE: assert property (@(posedge clock) disable iff (reset)
    (ctrl_reg.magnitude == 5'h00) |-> !(windowOpen && corrState_reg == CORR_IDLE))
    else $error("zero magnitude armed a correction");

  AST_STAGE_WRAP: assert property (@(posedge clock) disable iff (reset)
    secondPulse |=> (stage_reg == STAGE_ZERO) && secondTick)
    else $error("stage did not wrap at the end of a second");

  AST_READBACK: assert property (@(posedge clock) disable iff (reset)
    ctrlRead |=> regReadValid && (regReadData == $past(ctrl_reg)))
    else $error("control register read back wrong");

  AST_CTRL_WRITE: assert property (@(posedge clock) disable iff (reset)
    ctrlWrite |=> (ctrl_reg == $past(regRequest.data)))
    else $error("control write did not land");

  AST_CTRL_HOLD: assert property (@(posedge clock) disable iff (reset)
    !ctrlWrite |=> $stable(ctrl_reg))
    else $error("control register changed without a write");

  AST_READ_OTHER: assert property (@(posedge clock) disable iff (reset)
    (regRequest.read && !ctrlRead) |=> regReadValid && (regReadData == READ_ZERO))
    else $error("unmapped read returned data");

  AST_READ_VALID: assert property (@(posedge clock) disable iff (reset)
    regRequest.read |=> regReadValid)
    else $error("read strobe gave no valid pulse");

  AST_READ_PULSE: assert property (@(posedge clock) disable iff (reset)
    !regRequest.read |=> !regReadValid)
    else $error("read valid without a read");

  AST_ARM: assert property (@(posedge clock) disable iff (reset)
    (windowOpen && (corrState_reg == CORR_IDLE)) |=> (corrState_reg == CORR_PENDING))
    else $error("selected second of an affected minute was not armed");

  AST_PENDING_SECOND: assert property (@(posedge clock) disable iff (reset)
    (corrState_reg == CORR_PENDING) |-> (secondPos == CORR_SECOND))
    else $error("correction still pending outside the selected second");

  AST_LAST_MINUTES: assert property (@(posedge clock) disable iff (reset)
    (minutePos >= MINUTE_LIMIT) |-> !minuteAffected)
    else $error("minute past the correctable part of the cycle was affected");

  AST_STAGE_HOLD: assert property (@(posedge clock) disable iff (reset)
    !stageTick |=> $stable(stage_reg))
    else $error("stage moved without a divide-by-128 pulse");

endmodule

`default_nettype wire

// *** core/rtcc_divider.sv ***
/*
  Oscillator prescaler: divide-by-128 pulse and the 512 Hz square tap.
  Assumes oscTick is a one-cycle pulse per crystal cycle, synchronous to clock.
*/

`default_nettype none

module rtcc_divider
  import rtcc_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // oscillator
  input  wire logic oscTick,
  // outputs
  output var  logic stageTick,
  output var  logic testSquare
);

  // ****************************************************************
  // prescaler
  // ****************************************************************
  logic [6:0] prescale_reg;
  logic [6:0] prescale_next;
  logic       stageTick_next;

  assign prescale_next  = oscTick ? prescale_reg + 7'h01 : prescale_reg;
  assign stageTick_next = oscTick && (prescale_reg == PRESCALE_LAST);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prescale_reg <= 7'h00;
      stageTick    <= 1'b0;
      testSquare   <= 1'b0;
    end else begin
      prescale_reg <= prescale_next;
      stageTick    <= stageTick_next;
      // tap sits before any blanking or splitting, so calibration cannot reach it
      testSquare   <= prescale_next[TAP_BIT];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_TAP_EDGE: assert property (@(posedge clock) disable iff (reset)
    $changed(testSquare) |-> $past(oscTick) && ($past(prescale_reg[4:0]) == TAP_HALF_LAST))
    else $error("test tap moved off a 32-cycle boundary");

endmodule

`default_nettype wire

// *** core/rtcc_pkg.sv ***
/*
  Shared constants and types of the calibration and test-output block.
  Assumes one 25 MHz clock and a one-cycle oscillator tick per crystal cycle.
*/
// What this block does
// - Correction is made by blanking or splitting pulses out of the divide-by-128 stage.
// - The correction magnitude is the unsigned value 0 to 31 in control bits 4 to 0.
// - Control bit 5 set means positive correction (clock runs faster), clear means negative.
// - Correction runs over a 64-minute cycle and only its first 62 minutes can be touched.
// - One second per affected minute is altered: lengthened by 128 or shortened by 256 cycles.
// - The first 2N minutes of each cycle are affected, N being the magnitude.
// - With the frequency-test bit (bit 6) set the test pin toggles at 512 Hz.
// - The calibration value never changes the frequency of the 512 Hz test signal.
// - With the frequency-test bit clear the test pin shows control bit 7 as a static level.
// - The test pin is open drain: it only pulls low and is released for a high level.

`default_nettype none

package rtcc_pkg;

  // ****************************************************************
  // rates and divider
  // ****************************************************************
  localparam int OSC_HZ  = 32768;
  localparam int TEST_HZ = 512;
  // half a test period in oscillator cycles picks the prescaler tap
  localparam int TAP_BIT = $clog2(OSC_HZ / (2 * TEST_HZ));

  localparam logic [6:0] PRESCALE_LAST = 7'h7F;
  localparam logic [4:0] TAP_HALF_LAST = 5'h1F;

  localparam logic [7:0] STAGE_LAST       = 8'hFF;
  localparam logic [7:0] STAGE_ZERO       = 8'h00;
  localparam logic [7:0] STAGE_STEP       = 8'h01;
  localparam logic [7:0] STAGE_SPLIT_STEP = 8'h03;
  localparam logic [7:0] STAGE_CORR_POINT = 8'h80;

  // ****************************************************************
  // calibration cycle
  // ****************************************************************
  localparam logic [5:0] SECOND_LAST  = 6'h3B;
  localparam logic [5:0] SECOND_ZERO  = 6'h00;
  localparam logic [5:0] CORR_SECOND  = 6'h00;
  localparam logic [5:0] MINUTE_ZERO  = 6'h00;
  localparam logic [5:0] MINUTE_STEP  = 6'h01;
  localparam logic [5:0] SECOND_STEP  = 6'h01;
  localparam logic [5:0] MINUTE_LIMIT = 6'h3E;

  // ****************************************************************
  // register
  // ****************************************************************
  localparam logic [5:0] CTRL_ADDR  = 6'h07;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  typedef struct packed {
    logic       levelOut;
    logic       frequency_test_enable;
    logic       signPositive;
    logic [4:0] magnitude;
  } rtcc_ctrl_type;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [5:0] addr;
    logic [7:0] data;
  } rtcc_regreq_type;

  typedef enum logic [0:0] {
    CORR_IDLE,
    CORR_PENDING
  } rtcc_corr_type;

endpackage

`default_nettype wire

// *** testbench/rtcc_crystal_model.sv ***
/*
  Far-side model: crystal tick source, pin pull-up and a frequency meter.
  Assumes the bench releases reset on a falling clock edge by non-blocking assignment.
*/

`default_nettype none

module rtcc_crystal_model #(
  parameter int TICK_EVERY = 1
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // oscillator
  output var  logic        oscTick,
  output var  logic [31:0] tickCount,
  // pin seen through the pull-up
  input  wire logic        testPinOut,
  input  wire logic        testPinEnableN,
  output var  logic        pinLevel,
  // frequency meter
  output var  logic [15:0] highTicks,
  output var  logic [15:0] lowTicks,
  output var  logic [15:0] edgeCount
);
  timeunit 1ns;
  timeprecision 1ps;

  int          phase;
  logic        lastLevel;
  logic [15:0] runTicks;

  // ****************************************************************
  // crystal ticks, launched on the falling edge
  // ****************************************************************
  always @(negedge clock or posedge reset) begin
    if (reset) begin
      phase   <= 0;
      oscTick <= 1'b0;
    end else begin
      phase   <= (phase == TICK_EVERY - 1) ? 0 : phase + 1;
      oscTick <= (phase == 0);
    end
  end

  // released pin floats up to the pull-up level
  assign pinLevel = testPinEnableN ? 1'b1 : testPinOut;

  // ****************************************************************
  // meter: ticks spent in each level between pin edges
  // ****************************************************************
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tickCount <= '0;
      lastLevel <= 1'b1;
      runTicks  <= '0;
      highTicks <= '0;
      lowTicks  <= '0;
      edgeCount <= '0;
    end else begin
      tickCount <= tickCount + 32'(oscTick);
      lastLevel <= pinLevel;
      if (pinLevel != lastLevel) begin
        if (lastLevel) begin
          highTicks <= runTicks;
        end else begin
          lowTicks <= runTicks;
        end
        runTicks  <= 16'(oscTick);
        edgeCount <= edgeCount + 16'h0001;
      end else begin
        runTicks <= runTicks + 16'(oscTick);
      end
    end
  end
endmodule

`default_nettype wire

// *** testbench/tb_rtc_calibration_and_test_output.sv ***
/*
  Self-checking bench for the calibration and test-output block.
  Assumes the crystal model ticks once per clock so a second lasts 32768 cycles.
*/

`default_nettype none

module tb_rtc_calibration_and_test_output
  import rtcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] expRead;
    logic       expPin;
    logic       expSquare;
  } rtcc_row_type;

  localparam logic [31:0] HALF_TICKS = 32'(OSC_HZ / (2 * TEST_HZ));
  localparam rtcc_row_type ROWS [9] = '{
    '{8'h00, 8'h00, 1'b0, 1'b0}, '{8'h80, 8'h80, 1'b1, 1'b0},
    '{8'h1F, 8'h1F, 1'b0, 1'b0}, '{8'h9F, 8'h9F, 1'b1, 1'b0},
    '{8'h3F, 8'h3F, 1'b0, 1'b0}, '{8'h40, 8'h40, 1'b0, 1'b1},
    '{8'h7F, 8'h7F, 1'b0, 1'b1}, '{8'h5F, 8'h5F, 1'b0, 1'b1},
    '{8'hC1, 8'hC1, 1'b0, 1'b1}
  };

  logic            clock;
  logic            reset;
  rtcc_regreq_type regRequest;
  logic [7:0]      regReadData;
  logic            regReadValid;
  logic            secondTick;
  logic            oscTick;
  logic            testPinOut;
  logic            testPinEnableN;
  logic            pinLevel;
  logic [31:0]     tickCount;
  logic [15:0]     highTicks;
  logic [15:0]     lowTicks;
  logic [15:0]     edgeCount;
  logic [31:0]     lastTick;
  logic [31:0]     secondLen;
  logic [7:0]      rd;
  int              nSeconds;
  int              n_errors;
  int              n_compared;

  rtcc_calibration i_rtcc_calibration (
    .clock          (clock),
    .reset          (reset),
    .oscTick        (oscTick),
    .regRequest     (regRequest),
    .regReadData    (regReadData),
    .regReadValid   (regReadValid),
    .secondTick     (secondTick),
    .testPinIn      (pinLevel),
    .testPinOut     (testPinOut),
    .testPinEnableN (testPinEnableN)
  );

  rtcc_crystal_model #(.TICK_EVERY(1)) i_rtcc_crystal_model (
    .clock          (clock),
    .reset          (reset),
    .oscTick        (oscTick),
    .tickCount      (tickCount),
    .testPinOut     (testPinOut),
    .testPinEnableN (testPinEnableN),
    .pinLevel       (pinLevel),
    .highTicks      (highTicks),
    .lowTicks       (lowTicks),
    .edgeCount      (edgeCount)
  );

  // ****************************************************************
  // clock and second-length monitor
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // the first interval after reset is partial, so only tick-to-tick spans count
  always @(posedge clock) begin
    if (!reset && secondTick === 1'b1) begin
      if (nSeconds > 0) begin
        secondLen = tickCount - lastTick;
      end
      lastTick = tickCount;
      nSeconds++;
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [5:0] addr, input logic [7:0] data);
    @(negedge clock);
    regRequest = '{write: 1'b1, read: 1'b0, addr: addr, data: data};
    @(negedge clock);
    regRequest = '0;
  endtask

  task automatic regRead(input logic [5:0] addr, output logic [7:0] data);
    @(negedge clock);
    regRequest = '{write: 1'b0, read: 1'b1, addr: addr, data: 8'h00};
    @(negedge clock);
    check(32'(regReadValid), 32'h1);
    data = regReadData;
    regRequest = '0;
    @(negedge clock);
    check(32'(regReadValid), 32'h0);
  endtask

  task automatic waitEdges(input int n);
    logic [15:0] start;
    start = edgeCount;
    for (int k = 0; k < 2000 && int'(edgeCount - start) < n; k++) begin
      @(negedge clock);
    end
    if (int'(edgeCount - start) < n) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, edgeCount - start, n);
      tally_and_finish();
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    regRequest = '0;
    nSeconds = 0;
    n_errors = 0;
    n_compared = 0;
    lastTick = '0;
    secondLen = '0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    check(32'(testPinEnableN), 32'h1);
    check(32'(testPinOut), 32'h0);
    check(32'(regReadValid), 32'h0);
    check(32'(secondTick), 32'h0);
    reset <= 1'b0;
    regRead(CTRL_ADDR, rd);
    check(32'(rd), 32'(CTRL_RESET));
    check(32'(pinLevel), 32'h0);
    for (int i = 0; i < 9; i++) begin
      regWrite(CTRL_ADDR, ROWS[i].data);
      regRead(CTRL_ADDR, rd);
      check(32'(rd), 32'(ROWS[i].expRead));
      if (ROWS[i].expSquare) begin
        waitEdges(3);
        check(32'(highTicks), HALF_TICKS);
        check(32'(lowTicks), HALF_TICKS);
      end else begin
        check(32'(pinLevel), 32'(ROWS[i].expPin));
      end
      check(32'(testPinOut), 32'h0);
    end
    // unmapped places neither store nor return anything
    regWrite(6'h08, 8'hFF);
    regRead(CTRL_ADDR, rd);
    check(32'(rd), 32'(ROWS[8].expRead));
    regRead(6'h08, rd);
    check(32'(rd), 32'(READ_ZERO));
    // write and read on one edge: the read sees the old value
    regWrite(CTRL_ADDR, 8'h80);
    @(negedge clock);
    regRequest = '{write: 1'b1, read: 1'b1, addr: CTRL_ADDR, data: 8'h00};
    @(negedge clock);
    check(32'(regReadData), 32'h80);
    regRequest = '0;
    regRead(CTRL_ADDR, rd);
    check(32'(rd), 32'h0);
    check(32'(pinLevel), 32'h0);
    // a reset in mid-run clears the control byte and releases the pin
    regWrite(CTRL_ADDR, 8'hC5);
    @(negedge clock);
    reset <= 1'b1;
    repeat (2) @(negedge clock);
    check(32'(testPinEnableN), 32'h1);
    check(32'(regReadValid), 32'h0);
    check(32'(secondTick), 32'h0);
    reset <= 1'b0;
    @(negedge clock);
    check(32'(pinLevel), 32'h0);
    regRead(CTRL_ADDR, rd);
    check(32'(rd), 32'(CTRL_RESET));
    // uncorrected seconds keep the full divider length
    for (int k = 0; k < 80000 && nSeconds < 2; k++) begin
      @(negedge clock);
    end
    check(32'(nSeconds >= 2), 32'h1);
    check(secondLen, 32'(OSC_HZ));
    tally_and_finish();
  end
endmodule

`default_nettype wire
